// ### hdl/fbcfe_pkg.sv
// constants and types shared by the flash bus host controller
package fbcfe_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int ADDR_LINE_ZERO = 0;
    localparam int ADDR_LINE_ONE = 1;
    localparam int ADDR_LINE_SIX = 6;
    localparam int SECTOR_LO = 16;
    localparam int SECTOR_W = 3;
    // identification low addresses: maker, part, sector protection
    localparam logic [7:0] ID_MAKER_LOW = 8'h00;
    localparam logic [7:0] ID_PART_LOW = 8'h01;
    localparam logic [7:0] ID_PROT_LOW = 8'h02;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    // strobes narrower than this are taken as noise by the device
    localparam int GLITCH_NS = 10;
    // least width rounds up, plus one cycle so we are clearly wider
    localparam int STROBE_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
    // input synchroniser depth on the data pins
    localparam int SYNC_CYC = 3;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // user operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ = 2'b00, // array or command-mode read
        OP_WRITE = 2'b01, // one command-register bus write
        OP_HW_ID = 2'b10 // read with high voltage on address line nine
    } fbcfe_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WR_LOW = 3'b010,
        ST_WR_HOLD = 3'b011,
        ST_RD_WAIT = 3'b100,
        ST_RD_END = 3'b101
    } fbcfe_state_t;
endpackage

// ### hdl/fbcfe_host.sv
// host-side bus controller driving a byte-wide asynchronous flash
`timescale 1ns/1ps
module fbcfe_host #(
    parameter int ACCESS_CYC = 8, // read access wait before sampling
    parameter int SETUP_CYC = 2, // address and high-voltage settle
    parameter int HOLD_CYC = 1 // data and select hold after write-enable rise
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // user request port
    input wire logic req,
    input wire logic [1:0] req_op,
    input wire logic [fbcfe_pkg::ADDR_W-1:0] req_addr,
    input wire logic [fbcfe_pkg::DATA_W-1:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [fbcfe_pkg::DATA_W-1:0] rdata,
    // flash pins
    output logic [fbcfe_pkg::ADDR_W-1:0] flash_addr,
    output logic [fbcfe_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [fbcfe_pkg::DATA_W-1:0] dq_i,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic id_high_voltage
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fbcfe_pkg::fbcfe_state_t st;
        logic [1:0] op;
        logic [fbcfe_pkg::CNT_W-1:0] cnt;
        logic [fbcfe_pkg::ADDR_W-1:0] addr;
        logic [fbcfe_pkg::DATA_W-1:0] dout;
        logic [fbcfe_pkg::DATA_W-1:0] din;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic hv;
        logic done;
        logic [fbcfe_pkg::DATA_W-1:0] sync1;
        logic [fbcfe_pkg::DATA_W-1:0] sync2;
        logic [fbcfe_pkg::DATA_W-1:0] sync3;
    } fbcfe_regs_t;

    fbcfe_regs_t r;
    fbcfe_regs_t next_r;

    // counter load values, cut to counter width once
    localparam logic [fbcfe_pkg::CNT_W-1:0] LD_SETUP = fbcfe_pkg::CNT_W'(SETUP_CYC);
    localparam logic [fbcfe_pkg::CNT_W-1:0] LD_STROBE = fbcfe_pkg::CNT_W'(fbcfe_pkg::STROBE_CYC);
    localparam logic [fbcfe_pkg::CNT_W-1:0] LD_HOLD = fbcfe_pkg::CNT_W'(HOLD_CYC);
    // access time plus synchroniser latency before the sample is trusted
    localparam logic [fbcfe_pkg::CNT_W-1:0] LD_ACCESS =
        fbcfe_pkg::CNT_W'(ACCESS_CYC + fbcfe_pkg::SYNC_CYC);

    // address seen by the device during a hardware id read
    function automatic logic [fbcfe_pkg::ADDR_W-1:0] id_addr(
        input logic [fbcfe_pkg::ADDR_W-1:0] a
    );
        logic [fbcfe_pkg::ADDR_W-1:0] t;
        t = a;
        t[fbcfe_pkg::ADDR_LINE_ONE] = 1'b0;
        return t;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // one sequencer owns every strobe so no two can race
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        // data pins are asynchronous: three flops deep
        next_r.sync1 = dq_i;
        next_r.sync2 = r.sync1;
        next_r.sync3 = r.sync2;
        if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 1'b1;
        end
        unique case (r.st)
            fbcfe_pkg::ST_IDLE: begin
                if (req) begin
                    next_r.op = req_op;
                    next_r.dout = req_wdata;
                    next_r.cnt = LD_SETUP;
                    next_r.st = fbcfe_pkg::ST_SETUP;
                    next_r.hv = (req_op == fbcfe_pkg::OP_HW_ID);
                    next_r.addr = (req_op == fbcfe_pkg::OP_HW_ID) ? id_addr(req_addr) : req_addr;
                    next_r.oe_n = 1'b1;
                    next_r.ce_n = (req_op != fbcfe_pkg::OP_WRITE);
                end
            end
            fbcfe_pkg::ST_SETUP: begin
                if (r.cnt == '0) begin
                    if (r.op == fbcfe_pkg::OP_WRITE) begin
                        next_r.we_n = 1'b0;
                        next_r.dq_oe = 1'b1;
                        next_r.cnt = LD_STROBE;
                        next_r.st = fbcfe_pkg::ST_WR_LOW;
                    end else begin
                        next_r.ce_n = 1'b0;
                        next_r.oe_n = 1'b0;
                        next_r.cnt = LD_ACCESS;
                        next_r.st = fbcfe_pkg::ST_RD_WAIT;
                    end
                end
            end
            fbcfe_pkg::ST_WR_LOW: begin
                // pulse kept wider than the noise filter
                if (r.cnt == '0) begin
                    next_r.we_n = 1'b1;
                    next_r.cnt = LD_HOLD;
                    next_r.st = fbcfe_pkg::ST_WR_HOLD;
                end
            end
            fbcfe_pkg::ST_WR_HOLD: begin
                // data stays driven past the rising edge that latches it
                if (r.cnt == '0) begin
                    next_r.ce_n = 1'b1;
                    next_r.dq_oe = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st = fbcfe_pkg::ST_IDLE;
                end
            end
            fbcfe_pkg::ST_RD_WAIT: begin
                // a value counts once the last two stages agree
                if (r.cnt == '0 && r.sync2 == r.sync3) begin
                    next_r.din = r.sync3;
                    next_r.oe_n = 1'b1;
                    next_r.ce_n = 1'b1;
                    next_r.st = fbcfe_pkg::ST_RD_END;
                end
            end
            fbcfe_pkg::ST_RD_END: begin
                // high voltage dropped only after the strobes are released
                next_r.hv = 1'b0;
                next_r.done = 1'b1;
                next_r.st = fbcfe_pkg::ST_IDLE;
            end
            default: begin
                next_r.st = fbcfe_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // strobes reset inactive so nothing can look like a write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.st <= fbcfe_pkg::ST_IDLE;
            r.ce_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.we_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign busy = (r.st != fbcfe_pkg::ST_IDLE);
    assign done = r.done;
    assign rdata = r.din;
    assign flash_addr = r.addr;
    assign dq_o = r.dout;
    assign dq_oe = r.dq_oe;
    assign ce_n = r.ce_n;
    assign oe_n = r.oe_n;
    assign we_n = r.we_n;
    assign id_high_voltage = r.hv;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // read strobe pairing
    a_read_strobes: assert property (@(posedge clk) disable iff (!arst_n)
        !oe_n |-> !ce_n && !dq_oe && we_n)
        else $error("output-enable low without select or with host driving");

    a_read_hold: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(oe_n) |-> !oe_n[*8])
        else $error("read strobe released before access time");

    a_write_entry: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(we_n) |-> !ce_n && oe_n && !$past(ce_n))
        else $error("write-enable fell without select low and output-enable high");

    a_write_width: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(we_n) |-> !we_n[*3] ##1 we_n ##1 (!ce_n && dq_oe))
        else $error("write pulse too short or data not held past rise");

    // hardware id read in its strobed phase
    logic st_is_hwid;
    assign st_is_hwid = (r.op == fbcfe_pkg::OP_HW_ID) && (r.st == fbcfe_pkg::ST_RD_WAIT);

    // high voltage spans the id read
    a_hv_span: assert property (@(posedge clk) disable iff (!arst_n)
        (st_is_hwid && !oe_n) |-> id_high_voltage)
        else $error("id read without high voltage on line nine");

    // line one low on id read
    a_id_line_one: assert property (@(posedge clk) disable iff (!arst_n)
        (id_high_voltage && !ce_n) |-> !flash_addr[fbcfe_pkg::ADDR_LINE_ONE])
        else $error("line one high during hardware id read");
endmodule // fbcfe_host

// ### sim/fbcfe_flash_model.sv
// behavioural flash device answering the host controller
`timescale 1ns/1ps
module fbcfe_flash_model #(
    parameter logic [7:0] MAKER = 8'h8C, // arbitrary, odd parity
    parameter logic [7:0] PART = 8'h15, // arbitrary, odd parity
    parameter logic [7:0] PROT = 8'h00 // shipped unprotected
) (
    // flash pins
    input wire logic [18:0] addr,
    input wire logic [7:0] din,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic id_high_voltage,
    output logic [7:0] dq
);
    // powers up in read mode; supply never dips below lockout here
    logic id_mode = 1'b0;
    logic [7:0] rd;
    logic [7:0] held = 8'h00;
    logic drv;
    // a rise counts only after a seen fall at least 10 ns back
    realtime t_fall = 0.0;
    logic armed = 1'b0;
    always @(negedge we_n) begin
        t_fall = $realtime;
        armed = 1'b1;
    end
    // command byte taken at write-enable rise
    // no algorithm runs here, so suspend, resume and other codes fall to read mode
    always @(posedge we_n) begin
        if (armed && !ce_n && oe_n && ($realtime - t_fall) >= 10.0) id_mode = (din == 8'h90);
        armed = 1'b0;
    end
    // id byte from lines zero, one, six
    always_comb begin
        if (addr[1] && !addr[0] && !addr[6]) rd = {7'h00, PROT[addr[18:16]]};
        else if (addr[1] || addr[6]) rd = 8'h00; // line six high, or lines one and zero both high, reads junk
        else rd = addr[0] ? PART : MAKER;
        if (!(id_mode || id_high_voltage)) rd = addr[7:0] ^ {5'h00, addr[18:16]};
    end
    // drive only while selected and output enabled
    assign drv = !ce_n && !oe_n && we_n;
    always @* if (drv) held = rd;
    // released bus shows the inverse so a late sample cannot pass
    assign dq = drv ? rd : ~held;
endmodule // fbcfe_flash_model

// ### sim/tb_top.sv
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] MAKER = 8'h8C; // arbitrary, odd parity
    localparam logic [7:0] PART = 8'h15; // arbitrary, odd parity
    localparam logic [7:0] PROT = 8'h24;
    // user port and pins
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req = 1'b0;
    logic [1:0] req_op = 2'b00;
    logic [18:0] req_addr = 19'h00000;
    logic [7:0] req_wdata = 8'h00;
    logic busy, done, dq_oe, ce_n, oe_n, we_n, hv;
    logic [7:0] rdata, dq_o, dq_i;
    logic [18:0] flash_addr;
    logic [8:0] notes[$];
    logic [8:0] e;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 96;
    always #5 clk = ~clk;
    fbcfe_host DUT (.clk(clk), .arst_n(arst_n), .req(req), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
        .rdata(rdata), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe),
        .dq_i(dq_i), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .id_high_voltage(hv));
    fbcfe_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(PROT)) flash (
        .addr(flash_addr), .din(dq_o), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .id_high_voltage(hv), .dq(dq_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [7:0] arr(input logic [18:0] a);
        return a[7:0] ^ {5'h00, a[18:16]};
    endfunction
    // one user operation; reads note the byte they must return
    task automatic op(input logic [1:0] o, input logic [18:0] a, input logic [7:0] d,
            input logic chk, input logic [7:0] exp);
        int n;
        n = 0;
        notes.push_back({chk, exp});
        @(posedge clk);
        req <= 1'b1;
        req_op <= o;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        check({7'h00, busy}, 8'h01);
        while (done !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) begin
            n_fail++;
            conclude();
        end
    endtask
    // result watcher takes the oldest note at each done pulse
    always @(negedge clk) begin
        if (arst_n && done === 1'b1) begin
            e = notes.pop_front();
            if (e[8]) check(rdata, e[7:0]);
        end
    end
    // write strobe only with select low and output-enable high
    // strobes that move on one edge are looked at once they have settled
    always @(negedge we_n) if (arst_n) #1 check({7'h00, oe_n & ~ce_n}, 8'h01);
    // output-enable only with select low and no write
    always @(negedge oe_n) if (arst_n) #1 check({6'h00, ce_n, we_n}, 8'h01);
    initial begin
        #50000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [18:0] a;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // random array reads need no command after reset
        for (int i = 0; i < 6; i++) begin
            a = 19'($random(seed));
            op(2'b00, a, 8'h00, 1'b1, arr(a));
        end
        $display("test array reads done");
        // high-voltage id: line one forced low by the host, line six held low, line zero picks maker or part, other lines random
        for (int i = 0; i < 4; i++) begin
            a = 19'($random(seed));
            a = {a[18:7], 1'b0, a[5:2], i[1:0]};
            op(2'b10, a, 8'h00, 1'b1, i[0] ? PART : MAKER);
        end
        $display("test hardware id done");
        // command id, maker, part and protection of every sector
        op(2'b01, 19'h00555, 8'h90, 1'b0, 8'h00);
        op(2'b00, 19'h30000, 8'h00, 1'b1, MAKER);
        op(2'b00, 19'h50001, 8'h00, 1'b1, PART);
        for (int s = 0; s < 8; s++)
            op(2'b00, {s[2:0], 16'h0002}, 8'h00, 1'b1, {7'h00, PROT[s]});
        // reset command returns to array reads
        op(2'b01, 19'h00000, 8'hF0, 1'b0, 8'h00);
        op(2'b00, 19'h10001, 8'h00, 1'b1, arr(19'h10001));
        $display("test command id done");
        // a wrong command abandons id mode
        op(2'b01, 19'h00555, 8'h90, 1'b0, 8'h00);
        op(2'b01, 19'h00555, 8'h55, 1'b0, 8'h00);
        op(2'b00, 19'h00000, 8'h00, 1'b1, arr(19'h00000));
        $display("test bad command done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule // tb_top
